// *** src/switch_threshold_irq_assert.sv ***
`timescale 1ns/1ns
`include "switch_threshold_irq_defines.svh"
// Notes on behaviour
// - comparator mode: one of four levels per group of four inputs
// - adc mode compares each sample against a 10-bit threshold code
// - inputs 0..11 each pick one of eight programmable adc levels
// - common adc level shared by inputs 0..11, evaluated independently
// - inputs 12..17 compared against low and high dual levels
// - inputs 18..22 compared against low, mid and high triple levels
// - input 23 uses triple levels plus two own levels
// - six wetting current settings; zero milliamp after reset
// - interrupt is active low open drain, pulled low on events
// - scheme bit: zero static, one dynamic toggling
// - static: low on event, released at cs rise only after status read
// - status captured at first sclk rise of frame; cleared by status read
// - dynamic: alternate active low and inactive high intervals while unread
// - dynamic: read while low releases line and clears at cs rise
// - dynamic: read while high clears, no further assertion for those events
// - scheme defaults to static after reset
// - scheme change accepted only while trigger bit is zero
module switch_threshold_irq_assert
    import switch_threshold_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    // configuration
    input wire logic trigger,
    input wire logic schemeSelect,
    input wire logic [23:0] adcModeSel,
    input wire logic [11:0] comparator_level_select,
    input wire logic [79:0] adc_level_config_a,
    input wire logic [35:0] adc_level_config_b,
    input wire logic [9:0] shared_adc_level,
    input wire logic [9:0] dual_low_level,
    input wire logic [9:0] dual_high_level,
    input wire logic [9:0] triple_low_level,
    input wire logic [9:0] triple_mid_level,
    input wire logic [9:0] triple_high_level,
    input wire logic [9:0] last_input_level_four,
    input wire logic [9:0] last_input_level_five,
    input wire logic [2:0] wetting_setting_a,
    input wire logic wettingLoad,
    // measurements
    input wire logic [23:0] compResult,
    input wire logic [239:0] adcSample,
    input wire logic [23:0] sampleValid,
    input wire logic [31:0] adc_event_enable_a,
    input wire logic [7:0] otherEvents,
    // spi link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [7:0] spiCmd,
    // outputs
    output logic [1:0] compLevelOut [0:5],
    output logic [2:0] wettingOut,
    output logic schemeOut,
    output logic [31:0] statusSnap,
    output logic [23:0] aboveLevel,
    output logic [11:0] aboveShared,
    output logic [5:0] dualAbove,
    output logic [4:0] tripleAbove,
    output logic [1:0] lastExtraAbove,
    output logic intOut,
    output logic intOe
);

    // ---- comparator group levels
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : gComp
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    compLevelOut[g] <= COMP_2V0;
                end else begin
                    compLevelOut[g] <= comparator_level_select[2*g +: 2];
                end
            end
        end
    endgenerate

    // ---- adc threshold compare per input
    logic [9:0] adcLevel [0:7];
    logic [9:0] levelUsed [0:23];
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : gLvl
            assign adcLevel[i] = adc_level_config_a[10*i +: 10];
        end
        for (i = 0; i < 24; i++) begin : gIn
            logic [9:0] smp;
            assign smp = adcSample[10*i +: 10];
            if (i < 12) begin : gInd
                assign levelUsed[i] = adcLevel[adc_level_config_b[3*i +: 3]];
                always_ff @(posedge ref_clk or negedge arst_n) begin
                    if (!arst_n) begin
                        aboveShared[i] <= 1'b0;
                    end else if (sampleValid[i] && adcModeSel[i]) begin
                        aboveShared[i] <= smp > shared_adc_level;
                    end
                end
            end else if (i < 18) begin : gDual
                assign levelUsed[i] = dual_low_level;
                always_ff @(posedge ref_clk or negedge arst_n) begin
                    if (!arst_n) begin
                        dualAbove[i-12] <= 1'b0;
                    end else if (sampleValid[i] && adcModeSel[i]) begin
                        dualAbove[i-12] <= smp > dual_high_level;
                    end
                end
            end else begin : gTri
                assign levelUsed[i] = triple_low_level;
                always_ff @(posedge ref_clk or negedge arst_n) begin
                    if (!arst_n) begin
                        tripleAbove[i-18] <= 1'b0;
                    end else if (sampleValid[i] && adcModeSel[i]) begin
                        tripleAbove[i-18] <= (smp > triple_mid_level)
                            && (smp > triple_high_level);
                    end
                end
            end
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    aboveLevel[i] <= 1'b0;
                end else if (sampleValid[i]) begin
                    aboveLevel[i] <= adcModeSel[i] ? (smp > levelUsed[i]) : compResult[i];
                end
            end
        end
    endgenerate

    // input 23 own extra levels, on top of the triple ones
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lastExtraAbove <= 2'h0;
        end else if (sampleValid[23] && adcModeSel[23]) begin
            lastExtraAbove <= {adcSample[239:230] > last_input_level_five,
                               adcSample[239:230] > last_input_level_four};
        end
    end

    // ---- wetting current, only legal codes accepted
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wettingOut <= `WETTING_RESET;
        end else if (wettingLoad && wetting_setting_a <= WET_15MA) begin
            wettingOut <= wetting_setting_a;
        end
    end

    // ---- scheme select, locked while monitoring runs
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            schemeOut <= 1'b0;
        end else if (!trigger) begin
            schemeOut <= schemeSelect;
        end
    end

    // ---- event detection: crossings of enabled levels plus other sources
    logic [23:0] abovePrev_r;
    logic [31:0] newEvents;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            abovePrev_r <= 24'h000000;
        end else begin
            abovePrev_r <= aboveLevel;
        end
    end
    assign newEvents = {otherEvents, (aboveLevel ^ abovePrev_r)} & adc_event_enable_a;

    // ---- link domain: frame capture on sclk
    logic frameOpen_r;
    logic readStat_r;
    logic frameTgl_r;
    logic [7:0] cmdSync_r [0:1];
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            frameOpen_r <= 1'b0;
        end else begin
            frameOpen_r <= 1'b1;
        end
    end
    // command pins pass two stages before the decoder looks at them
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            cmdSync_r[0] <= 8'h00;
            cmdSync_r[1] <= 8'h00;
        end else begin
            cmdSync_r[0] <= spiCmd;
            cmdSync_r[1] <= cmdSync_r[0];
        end
    end
    // first sclk rise toggles a flag to the core; later rises decode the command
    // the last rise wins, so a stale command of the previous frame drops out
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            frameTgl_r <= 1'b0;
            readStat_r <= 1'b0;
        end else if (!cs_n && !frameOpen_r) begin
            frameTgl_r <= ~frameTgl_r;
            readStat_r <= 1'b0;
        end else if (!cs_n) begin
            readStat_r <= (cmdSync_r[1] == `STATUS_READ_CMD);
        end
    end

    // ---- crossings into core
    logic [2:0] tglSync_r;
    logic [1:0] csSync_r;
    logic [1:0] rdSync_r;
    logic csPrev_r;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tglSync_r <= 3'h0;
            csSync_r <= 2'h3;
            rdSync_r <= 2'h0;
            csPrev_r <= 1'b1;
        end else begin
            tglSync_r <= {tglSync_r[1:0], frameTgl_r};
            csSync_r <= {csSync_r[0], cs_n};
            rdSync_r <= {rdSync_r[0], readStat_r};
            csPrev_r <= csSync_r[1];
        end
    end
    logic frameStart;
    logic csRise;
    logic statusRead;
    // read flag is stable by the time cs rise has crossed two stages
    assign frameStart = tglSync_r[2] ^ tglSync_r[1];
    assign csRise = csSync_r[1] && !csPrev_r;
    assign statusRead = csRise && rdSync_r[1];

    // ---- status register, one cell per source, set beats clear
    logic [31:0] status_r;
    genvar b;
    generate
        for (b = 0; b < 32; b++) begin : gStat
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    status_r[b] <= 1'b0;
                end else if (newEvents[b]) begin
                    status_r[b] <= 1'b1;
                end else if (statusRead) begin
                    status_r[b] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            statusSnap <= 32'h00000000;
        end else if (frameStart) begin
            statusSnap <= status_r;
        end
    end

    // ---- interrupt line machine
    irq_state_type irqState_r;
    irq_state_type irqState_nxt;
    logic [`TIMER_WIDTH-1:0] timer_r;
    logic pending;
    assign pending = |newEvents || (|status_r);
    always_comb begin
        irqState_nxt = irqState_r;
        case (irqState_r)
            IRQ_IDLE: if (|newEvents) irqState_nxt = IRQ_LOW;
            IRQ_LOW: begin
                if (statusRead) irqState_nxt = |newEvents ? IRQ_LOW : IRQ_IDLE;
                else if (schemeOut && timer_r == `TIMER_WIDTH'(`INT_ACTIVE_CYC - 1))
                    irqState_nxt = IRQ_HIGH;
            end
            IRQ_HIGH: begin
                if (statusRead) irqState_nxt = |newEvents ? IRQ_LOW : IRQ_IDLE;
                else if (!schemeOut) irqState_nxt = IRQ_LOW;
                else if (timer_r == `TIMER_WIDTH'(`INT_INACTIVE_CYC - 1))
                    irqState_nxt = IRQ_LOW;
            end
            default: irqState_nxt = IRQ_IDLE;
        endcase
        if (!pending && irqState_nxt != IRQ_IDLE) irqState_nxt = IRQ_IDLE;
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqState_r <= IRQ_IDLE;
        end else begin
            irqState_r <= irqState_nxt;
        end
    end
    // interval timer restarts on every state change
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_r <= '0;
        end else if (irqState_nxt != irqState_r) begin
            timer_r <= '0;
        end else begin
            timer_r <= timer_r + `TIMER_WIDTH'(1);
        end
    end

    // open drain: output is always low, enable pulls the line
    assign intOut = 1'b0;
    assign intOe = (irqState_r == IRQ_LOW);

endmodule : switch_threshold_irq_assert

// *** src/switch_threshold_irq_defines.svh ***
`ifndef SWITCH_THRESHOLD_IRQ_DEFINES_SVH
`define SWITCH_THRESHOLD_IRQ_DEFINES_SVH
`define NUM_INPUTS 24
`define NUM_EVENTS 32
`define ADC_WIDTH 10
`define NUM_ADC_LEVELS 8
`define NUM_IND_INPUTS 12
`define DUAL_FIRST 12
`define TRIPLE_FIRST 18
`define LAST_INPUT 23
`define CLK_PERIOD_NS 50
`define INT_ACTIVE_US 2
`define INT_INACTIVE_US 2
`define INT_ACTIVE_CYC (((`INT_ACTIVE_US * 1000) / `CLK_PERIOD_NS) < 1 ? 1 : ((`INT_ACTIVE_US * 1000) / `CLK_PERIOD_NS))
`define INT_INACTIVE_CYC (((`INT_INACTIVE_US * 1000) / `CLK_PERIOD_NS) < 1 ? 1 : ((`INT_INACTIVE_US * 1000) / `CLK_PERIOD_NS))
`define TIMER_WIDTH 12
`define STATUS_READ_CMD 8'h01
`define WETTING_RESET 3'h0
`endif

// *** src/switch_threshold_irq_pkg.sv ***
package switch_threshold_irq_pkg;
    typedef enum logic [2:0] {
        WET_0MA = 3'h0,
        WET_1MA = 3'h1,
        WET_2MA = 3'h2,
        WET_5MA = 3'h3,
        WET_10MA = 3'h4,
        WET_15MA = 3'h5
    } wetting_type;
    typedef enum logic [1:0] {
        COMP_2V0 = 2'h0,
        COMP_2V7 = 2'h1,
        COMP_3V0 = 2'h2,
        COMP_4V0 = 2'h3
    } comp_level_type;
    typedef enum logic [2:0] {
        IRQ_IDLE = 3'b001,
        IRQ_LOW = 3'b010,
        IRQ_HIGH = 3'b100
    } irq_state_type;
endpackage : switch_threshold_irq_pkg

// *** tb/switch_threshold_irq_assert_props.sv ***
`timescale 1ns/1ns
module switch_threshold_irq_assert_props (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic trigger,
    input wire logic [31:0] adc_event_enable_a,
    input wire logic [7:0] otherEvents,
    input wire logic cs_n,
    input wire logic [7:0] spiCmd,
    input wire logic [2:0] wettingOut,
    input wire logic schemeOut,
    input wire logic intOut,
    input wire logic intOe
);
    logic [7:0] csHigh_r;
    logic [7:0] onCnt_r;
    wire evt = |(otherEvents & adc_event_enable_a[31:24]);
    // csHigh_r tells interval ends apart from releases caused by a frame
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            csHigh_r <= 8'h00;
            onCnt_r <= 8'h00;
        end else begin
            csHigh_r <= !cs_n ? 8'h00 : (csHigh_r == 8'hFF ? csHigh_r : csHigh_r + 8'h01);
            onCnt_r <= intOe ? onCnt_r + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    line_polarity_a: assert property (intOut == 1'b0) else $error("line driven high");
    reset_values_a: assert property ($rose(arst_n) |-> wettingOut == 3'h0 && !schemeOut)
        else $error("bad reset value");
    scheme_lock_a: assert property ($past(trigger) |-> $stable(schemeOut))
        else $error("scheme changed while running");
    wetting_range_a: assert property (wettingOut <= 3'h5) else $error("bad wetting code");
    event_sets_a: assert property (evt && !schemeOut |=> intOe) else $error("event not flagged");
    static_hold_a: assert property (!schemeOut && intOe && csHigh_r > 8'h08 |=> intOe || schemeOut)
        else $error("line released without read");
    read_release_a: assert property ($rose(cs_n) && spiCmd == 8'h01 |-> ##5 (!intOe) [*8])
        else $error("line not released after read");
    dyn_active_a: assert property (schemeOut && $fell(intOe) && csHigh_r > 8'h08 |-> onCnt_r == 8'h28)
        else $error("active interval length wrong");
    dyn_inactive_a: assert property (schemeOut && $fell(intOe) && csHigh_r > 8'h08
        |-> ##39 !intOe ##1 (intOe || csHigh_r < 8'h30)) else $error("inactive interval wrong");
    cover property (evt ##1 intOe);
    cover property ($rose(cs_n) && spiCmd == 8'h01 && intOe);
    cover property (schemeOut && $rose(intOe));
endmodule : switch_threshold_irq_assert_props
bind switch_threshold_irq_assert switch_threshold_irq_assert_props props_i (.*);

// *** tb/spi_host_model.sv ***
`timescale 1ns/1ns
module spi_host_model (
    output logic sclk,
    output logic cs_n,
    output logic [7:0] spiCmd
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        spiCmd = 8'hFF;
    end
    // link clock only runs inside a frame
    task automatic frame(input logic [7:0] cmd);
        #37;
        cs_n = 1'b0;
        spiCmd = cmd;
        repeat (4) begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        // released command lines must not keep the old value
        #160 spiCmd = ~cmd;
        #200;
    endtask : frame
endmodule : spi_host_model

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    logic ref_clk = 1'b0, arst_n = 1'b0, trigger = 1'b0, schemeSelect = 1'b0, wettingLoad = 1'b0;
    logic [23:0] adcModeSel = 24'h0, compResult = 24'h0, sampleValid = 24'h0;
    logic [11:0] comparator_level_select = 12'h0;
    logic [79:0] adc_level_config_a = 80'h0;
    logic [35:0] adc_level_config_b = 36'h0;
    logic [9:0] shared_adc_level = 10'h0, dual_low_level = 10'h0, dual_high_level = 10'h0;
    logic [9:0] triple_low_level = 10'h0, triple_mid_level = 10'h0, triple_high_level = 10'h0;
    logic [9:0] last_input_level_four = 10'h0, last_input_level_five = 10'h0;
    logic [2:0] wetting_setting_a = 3'h0, wettingOut;
    logic [239:0] adcSample = 240'h0;
    logic [31:0] adc_event_enable_a = 32'h0, statusSnap;
    logic [7:0] otherEvents = 8'h0, spiCmd;
    logic sclk, cs_n, intOut, intOe, schemeOut;
    logic [1:0] compLevelOut [0:5];
    logic [23:0] aboveLevel;
    logic [11:0] aboveShared;
    logic [5:0] dualAbove;
    logic [4:0] tripleAbove;
    logic [1:0] lastExtraAbove;
    int miscompares = 0, checks_done = 0, cycles = 0;
    switch_threshold_irq_assert DUT (.*);
    spi_host_model host (.*);
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic wait_oe(input logic v);
        for (int i = 0; i < 200 && intOe !== v; i++) @(posedge ref_clk);
        #1;
    endtask : wait_oe
    task automatic pulse_event;
        @(posedge ref_clk) otherEvents <= 8'h01;
        @(posedge ref_clk) otherEvents <= 8'h00;
    endtask : pulse_event
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    initial begin
        settle(12);
        @(posedge ref_clk) arst_n <= 1'b1;
        settle(2);
        check("wettingOut", wettingOut, 3'h0);
        check("schemeOut", schemeOut, 1'b0);
        for (int c = 0; c < 8; c++) begin
            @(posedge ref_clk) wetting_setting_a <= 3'(c);
            wettingLoad <= 1'b1;
            @(posedge ref_clk) wettingLoad <= 1'b0;
            settle(2);
            check("wettingOut", wettingOut, c < 6 ? c : 5);
        end
        @(posedge ref_clk) comparator_level_select <= 12'h1E4;
        adcModeSel <= 24'hFFFFFF;
        for (int i = 0; i < 8; i++) adc_level_config_a[10*i +: 10] <= 10'(100 * i);
        for (int i = 0; i < 12; i++) adc_level_config_b[3*i +: 3] <= 3'(i % 8);
        for (int i = 0; i < 24; i++) adcSample[10*i +: 10] <= 10'h15E;
        shared_adc_level <= 10'h15D;
        dual_low_level <= 10'h064;
        dual_high_level <= 10'h1F4;
        triple_low_level <= 10'h064;
        triple_mid_level <= 10'h0C8;
        triple_high_level <= 10'h12C;
        last_input_level_four <= 10'h12C;
        last_input_level_five <= 10'h190;
        @(posedge ref_clk) sampleValid <= 24'hFFFFFF;
        @(posedge ref_clk) sampleValid <= 24'h0;
        settle(3);
        for (int g = 0; g < 6; g++) check("compLevel", compLevelOut[g], 12'h1E4 >> (2 * g) & 3);
        for (int i = 0; i < 12; i++) check("aboveLevel", aboveLevel[i], (i % 8) < 4);
        check("aboveShared", aboveShared, 12'hFFF);
        check("lastExtra", lastExtraAbove, 2'h1);
        check("dualAbove", dualAbove, 6'h00);
        check("tripleAbove", tripleAbove, 5'h1F);
        check("aboveLevel", aboveLevel[23:12], 12'hFFF);
        @(posedge ref_clk) dual_low_level <= 10'h0C8;
        dual_high_level <= 10'h0C8;
        triple_high_level <= 10'h190;
        adcModeSel <= 24'hFFFFFE;
        @(posedge ref_clk) sampleValid <= 24'hFFFFFF;
        @(posedge ref_clk) sampleValid <= 24'h0;
        settle(3);
        check("aboveLevel", aboveLevel[17:12], 6'h3F);
        check("dualAbove", dualAbove, 6'h3F);
        check("tripleAbove", tripleAbove, 5'h00);
        check("aboveLevel", aboveLevel[0], 1'b0);
        $display("test config done");
        @(posedge ref_clk) trigger <= 1'b1;
        schemeSelect <= 1'b1;
        settle(3);
        check("schemeOut", schemeOut, 1'b0);
        @(posedge ref_clk) trigger <= 1'b0;
        schemeSelect <= 1'b0;
        pulse_event;
        settle(3);
        check("intOe", intOe, 1'b0);
        @(posedge ref_clk) adc_event_enable_a <= 32'h0100_0000;
        pulse_event;
        settle(2);
        check("intOe", intOe, 1'b1);
        host.frame(8'h02);
        settle(8);
        check("intOe", intOe, 1'b1);
        check("statusSnap", statusSnap[24], 1'b1);
        host.frame(8'h01);
        settle(8);
        check("intOe", intOe, 1'b0);
        host.frame(8'h02);
        settle(8);
        check("statusSnap", statusSnap[24], 1'b0);
        $display("test static done");
        @(posedge ref_clk) schemeSelect <= 1'b1;
        settle(3);
        check("schemeOut", schemeOut, 1'b1);
        pulse_event;
        wait_oe(1'b1);
        wait_oe(1'b0);
        wait_oe(1'b1);
        check("intOe", intOe, 1'b1);
        host.frame(8'h01);
        settle(6);
        check("intOe", intOe, 1'b0);
        pulse_event;
        wait_oe(1'b1);
        wait_oe(1'b0);
        host.frame(8'h01);
        settle(100);
        check("intOe", intOe, 1'b0);
        $display("test dynamic done");
        stop_test();
    end
endmodule : testbench
